/* File: logic/acc_pkg.sv */
package acc_pkg;
   // Register byte offsets on the APB
   localparam logic [11:0] ACC_OFF_CONTROL = 12'h000;
   localparam logic [11:0] ACC_OFF_RES_HIGH = 12'h004;
   localparam logic [11:0] ACC_OFF_RES_LOW = 12'h008;
   localparam logic [11:0] ACC_OFF_AMP_CFG = 12'h00C;
   // Control and amplifier register field positions
   localparam int ACC_CTL_BUSY_BIT = 0;
   localparam int ACC_CTL_DIV_BIT = 1;
   localparam int ACC_CTL_ROUTE_BIT = 2;
   localparam int ACC_CTL_DIFF_BIT = 3;
   localparam int ACC_CTL_CH_LSB = 4;
   localparam int ACC_CTL_CH_MSB = 7;
   localparam int ACC_AMP_EN_BIT = 0;
   // Reset values
   localparam logic [7:0] ACC_CONTROL_RESET = 8'h00;
   localparam logic ACC_AMP_RESET = 1'b0;
   // Result layout
   localparam int ACC_RESULT_BITS = 10;
   localparam int ACC_RES_HIGH_LSB = 2;
   localparam int ACC_RES_LOW_MSB = 1;
   localparam int ACC_RES_LOW_POS = 6;
   // Channel select codes
   localparam logic [3:0] ACC_CH_TEMP = 4'h7;
   localparam logic [3:0] ACC_CH_10 = 4'hA;
   localparam logic [3:0] ACC_CH_11 = 4'hB;
   localparam logic [3:0] ACC_CH_13 = 4'hD;
   localparam logic [3:0] ACC_CH_15 = 4'hF;
   localparam logic [3:0] ACC_CH_BASE = 4'h9;
   // Gate vector: index 0 temperature sensor, 1..6 channel pins 10..15
   localparam int ACC_GATES = 7;
   localparam int ACC_GATE_TEMP = 0;
   // Timing in converter clock ticks
   localparam logic [1:0] ACC_SETTLE_TICKS = 2'h3;
   localparam logic [3:0] ACC_DIV16_TERM = 4'hF;
   localparam logic [3:0] ACC_MSB_INDEX = 4'h9;
   // Cycles a new trial code needs to reach the synchronised comparator
   localparam logic [1:0] ACC_SYNC_AGE = 2'h2;
   // Sequencer states
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_SETTLE = 2'b01,
      ACC_CONVERT = 2'b10
   } acc_state_type;
endpackage : acc_pkg

/* File: logic/acc_prescaler.sv */
module acc_prescaler
   import acc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic run_in,
   input wire logic divide16_in,
   // Converter clock enable
   output logic tick_out
);
   // Divide counter
   logic [3:0] count_reg;

   // Counter held at zero while stopped, so no power is spent idling
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in || !run_in)
      begin
         count_reg <= 4'h0;
      end
      else
      begin
         count_reg <= count_reg + 4'h1;
      end
   end

   // One-cycle enable per converter clock
   always_comb
   begin
      if (!run_in)
      begin
         tick_out = 1'b0;
      end
      else if (divide16_in)
      begin
         tick_out = (count_reg == ACC_DIV16_TERM);
      end
      else
      begin
         tick_out = 1'b1;
      end
   end
endmodule : acc_prescaler

/* File: logic/acc_converter_control.sv */
// Behaviour
// - Routing: mux output and converter input on pins
// - Routing: top two channel pins not selectable
// - Routing: temperature sensor not convertible
// - Routed single-ended: only channels 10 to 13
// - Routed differential: pairs 10/11, 11/10 only
// - Routing keeps selected path on when idle
// - Three converter clocks sample and settle before the first trial
// - Mode bit: 0 single-ended, 1 differential
// - Busy clear stops prescaler and converter clock
// - Setting busy starts conversion with current settings
// - Completion clears busy and powers converter down
// - Writing zero aborts; restart by zero then one
// - Idle gates channels off unless routing or amplifier
// - Result split: high bits 9..2, low bits 1..0
// - Result registers read/write, loaded at completion
// - Low result register bits 5..0 read zero
// - Control layout: channel 7..4, mode, route, prescale, busy
// - Reset clears control register, converter idle
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module acc_converter_control
   import acc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Analog comparator result, asynchronous
   input wire logic compare_high_in,
   // Analog switch controls
   output logic [6:0] pos_gate_out,
   output logic [6:0] neg_gate_out,
   output logic mux_to_pin_out,
   output logic mux_minus_to_pin_out,
   output logic hold_from_pin_out,
   output logic hold_from_mux_out,
   // Converter core controls
   output logic converter_power_out,
   output logic sample_out,
   output logic [9:0] trial_code_out,
   output logic converter_busy_out
);
   // Software-visible registers
   logic [3:0] channel_reg;
   logic diff_reg;
   logic route_reg;
   logic divide_reg;
   logic busy_reg;
   logic amp_enable_reg;
   logic [7:0] result_high_reg;
   logic [1:0] result_low_reg;
   // Settings captured at conversion start
   logic [3:0] act_channel_reg;
   logic act_diff_reg;
   logic act_route_reg;
   logic act_divide_reg;
   // Sequencer
   acc_state_type state_reg;
   logic [1:0] settle_reg;
   logic [3:0] bit_index_reg;
   logic [9:0] sar_reg;
   logic [1:0] age_reg; // Cycles since the trial code changed
   // Comparator synchroniser
   logic compare_meta_reg;
   logic compare_sync_reg;
   // Read data register
   logic [31:0] rdata_reg;
   // Bus decode
   logic bus_setup;
   logic bus_write;
   logic hit_control;
   logic hit_res_high;
   logic hit_res_low;
   logic hit_amp;
   logic hit_any;
   // Conversion events
   logic tick;
   logic start;
   logic abort;
   logic finish;
   logic decide; // Converter tick with a fresh comparator answer
   logic [9:0] final_code;
   // Selected switch settings
   logic [3:0] sel_channel;
   logic sel_diff;
   logic sel_route;
   logic gates_on;
   logic [14:0] decoded;

   // Channel decode: valid bit, then positive and negative gates
   function automatic logic [14:0] acc_decode(input logic [3:0] ch, input logic diff, input logic route);
      logic [6:0] pos;
      logic [6:0] neg;
      logic [3:0] idx;
      logic [3:0] mate;
      logic ok;
      pos = 7'h00;
      neg = 7'h00;
      idx = ch - ACC_CH_BASE;
      mate = (ch ^ 4'h1) - ACC_CH_BASE;
      ok = 1'b0;
      if (!route)
      begin
         // Full channel set
         if (!diff && ch == ACC_CH_TEMP)
         begin
            pos[ACC_GATE_TEMP] = 1'b1;
            ok = 1'b1;
         end
         else if (ch >= ACC_CH_10)
         begin
            pos[idx[2:0]] = 1'b1;
            if (diff)
            begin
               neg[mate[2:0]] = 1'b1;
            end
            ok = 1'b1;
         end
      end
      else if (!diff)
      begin
         // Routed single-ended: 10..13 only, temp and 14/15 refused
         if (ch >= ACC_CH_10 && ch <= ACC_CH_13)
         begin
            pos[idx[2:0]] = 1'b1;
            ok = 1'b1;
         end
      end
      else
      begin
         // Routed differential: pairs 10/11 and 11/10 only
         if (ch == ACC_CH_10 || ch == ACC_CH_11)
         begin
            pos[idx[2:0]] = 1'b1;
            neg[mate[2:0]] = 1'b1;
            ok = 1'b1;
         end
      end
      return {ok, pos, neg};
   endfunction : acc_decode

   // APB decode
   assign bus_setup = psel_in && !penable_in;
   assign bus_write = psel_in && penable_in && pwrite_in;
   assign hit_control = (paddr_in == ACC_OFF_CONTROL);
   assign hit_res_high = (paddr_in == ACC_OFF_RES_HIGH);
   assign hit_res_low = (paddr_in == ACC_OFF_RES_LOW);
   assign hit_amp = (paddr_in == ACC_OFF_AMP_CFG);
   assign hit_any = hit_control || hit_res_high || hit_res_low || hit_amp;

   // Zero wait states; unmapped addresses answer with an error
   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && !hit_any;
   assign prdata_out = rdata_reg;

   // Read data captured in the setup phase
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else if (bus_setup && !pwrite_in)
      begin
         if (hit_control)
         begin
            rdata_reg <= {24'h00_0000, channel_reg, diff_reg, route_reg, divide_reg, busy_reg};
         end
         else if (hit_res_high)
         begin
            rdata_reg <= {24'h00_0000, result_high_reg};
         end
         else if (hit_res_low)
         begin
            rdata_reg <= {24'h00_0000, result_low_reg, 6'h00};
         end
         else if (hit_amp)
         begin
            rdata_reg <= {31'h0000_0000, amp_enable_reg};
         end
         else
         begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Conversion events
   assign abort = bus_write && hit_control && !pwdata_in[ACC_CTL_BUSY_BIT] && busy_reg;
   assign start = bus_write && hit_control && pwdata_in[ACC_CTL_BUSY_BIT] && (!busy_reg || finish);
   assign finish = decide && (bit_index_reg == 4'h0);
   // A bit is decided only once the synchroniser shows the current trial
   assign decide = (state_reg == ACC_CONVERT) && tick && (age_reg == ACC_SYNC_AGE);

   // Control register fields, cleared by reset
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         channel_reg <= ACC_CONTROL_RESET[ACC_CTL_CH_MSB:ACC_CTL_CH_LSB];
         diff_reg <= ACC_CONTROL_RESET[ACC_CTL_DIFF_BIT];
         route_reg <= ACC_CONTROL_RESET[ACC_CTL_ROUTE_BIT];
         divide_reg <= ACC_CONTROL_RESET[ACC_CTL_DIV_BIT];
      end
      else if (bus_write && hit_control)
      begin
         channel_reg <= pwdata_in[ACC_CTL_CH_MSB:ACC_CTL_CH_LSB];
         diff_reg <= pwdata_in[ACC_CTL_DIFF_BIT];
         route_reg <= pwdata_in[ACC_CTL_ROUTE_BIT];
         divide_reg <= pwdata_in[ACC_CTL_DIV_BIT];
      end
   end

   // Busy bit: software write wins over hardware clear
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         busy_reg <= ACC_CONTROL_RESET[ACC_CTL_BUSY_BIT];
      end
      else if (bus_write && hit_control)
      begin
         busy_reg <= pwdata_in[ACC_CTL_BUSY_BIT];
      end
      else if (finish)
      begin
         busy_reg <= 1'b0;
      end
   end

   // Amplifier enable bit, holds the idle path open
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         amp_enable_reg <= ACC_AMP_RESET;
      end
      else if (bus_write && hit_amp)
      begin
         amp_enable_reg <= pwdata_in[ACC_AMP_EN_BIT];
      end
   end

   // Snapshot of settings at start
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         act_channel_reg <= ACC_CONTROL_RESET[ACC_CTL_CH_MSB:ACC_CTL_CH_LSB];
         act_diff_reg <= 1'b0;
         act_route_reg <= 1'b0;
         act_divide_reg <= 1'b0;
      end
      else if (start)
      begin
         act_channel_reg <= pwdata_in[ACC_CTL_CH_MSB:ACC_CTL_CH_LSB];
         act_diff_reg <= pwdata_in[ACC_CTL_DIFF_BIT];
         act_route_reg <= pwdata_in[ACC_CTL_ROUTE_BIT];
         act_divide_reg <= pwdata_in[ACC_CTL_DIV_BIT];
      end
   end

   // Converter clock enable, stopped unless converting
   acc_prescaler u_prescaler
   (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .run_in(state_reg != ACC_IDLE),
      .divide16_in(act_divide_reg),
      .tick_out(tick)
   );

   // Comparator passes two flip-flops before use
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         compare_meta_reg <= 1'b0;
         compare_sync_reg <= 1'b0;
      end
      else
      begin
         compare_meta_reg <= compare_high_in;
         compare_sync_reg <= compare_meta_reg;
      end
   end

   // Sequencer state
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= ACC_IDLE;
      end
      else if (start)
      begin
         state_reg <= ACC_SETTLE;
      end
      else if (abort || finish)
      begin
         state_reg <= ACC_IDLE;
      end
      else
      begin
         case (state_reg)
            ACC_IDLE:
            begin
               state_reg <= ACC_IDLE;
            end
            ACC_SETTLE:
            begin
               // Leave after the third converter clock
               if (tick && settle_reg == ACC_SETTLE_TICKS - 2'h1)
               begin
                  state_reg <= ACC_CONVERT;
               end
            end
            ACC_CONVERT:
            begin
               state_reg <= ACC_CONVERT;
            end
            default:
            begin
               state_reg <= ACC_IDLE;
            end
         endcase
      end
   end

   // Settling tick counter
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in || start)
      begin
         settle_reg <= 2'h0;
      end
      else if (state_reg == ACC_SETTLE && tick)
      begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   // Trial code age, so the divide-by-1 rate never decides on a stale comparator
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in || start || decide)
      begin
         age_reg <= 2'h0;
      end
      else if (age_reg != ACC_SYNC_AGE)
      begin
         age_reg <= age_reg + 2'h1;
      end
   end

   // Successive approximation: keep or drop each trial bit
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in || start || state_reg == ACC_SETTLE)
      begin
         bit_index_reg <= ACC_MSB_INDEX;
         sar_reg <= 10'h200;
      end
      else if (decide)
      begin
         sar_reg[bit_index_reg] <= compare_sync_reg;
         if (bit_index_reg != 4'h0)
         begin
            sar_reg[bit_index_reg - 4'h1] <= 1'b1;
            bit_index_reg <= bit_index_reg - 4'h1;
         end
      end
   end

   // Final code includes the last decision
   always_comb
   begin
      final_code = sar_reg;
      final_code[0] = compare_sync_reg;
   end

   // High result: loaded at completion, hardware over software
   always_ff @(posedge sys_clk_in)
   begin
      if (finish)
      begin
         result_high_reg <= final_code[ACC_RESULT_BITS-1:ACC_RES_HIGH_LSB];
      end
      else if (bus_write && hit_res_high)
      begin
         result_high_reg <= pwdata_in[7:0];
      end
   end

   // Low result: same cycle as the high byte
   always_ff @(posedge sys_clk_in)
   begin
      if (finish)
      begin
         result_low_reg <= final_code[ACC_RES_LOW_MSB:0];
      end
      else if (bus_write && hit_res_low)
      begin
         result_low_reg <= pwdata_in[ACC_RES_LOW_POS+1:ACC_RES_LOW_POS];
      end
   end

   // Switch settings: snapshot while converting, live when idle
   assign sel_channel = busy_reg ? act_channel_reg : channel_reg;
   assign sel_diff = busy_reg ? act_diff_reg : diff_reg;
   assign sel_route = busy_reg ? act_route_reg : route_reg;
   assign gates_on = busy_reg || route_reg || amp_enable_reg;
   assign decoded = acc_decode(sel_channel, sel_diff, sel_route);

   // Analog switch drive
   always_comb
   begin
      if (gates_on)
      begin
         pos_gate_out = decoded[13:7];
         neg_gate_out = decoded[6:0];
      end
      else
      begin
         pos_gate_out = 7'h00;
         neg_gate_out = 7'h00;
      end
      mux_to_pin_out = sel_route;
      mux_minus_to_pin_out = sel_route && sel_diff;
      hold_from_pin_out = sel_route;
      hold_from_mux_out = !sel_route && gates_on;
   end

   // Converter core drive
   assign converter_power_out = (state_reg != ACC_IDLE);
   assign sample_out = (state_reg == ACC_SETTLE);
   assign trial_code_out = sar_reg;
   assign converter_busy_out = busy_reg;
endmodule : acc_converter_control

/* File: verif/acc_cc_asserts.sv */
module acc_cc_asserts
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // APB
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pslverr_out,
   // Switches and core
   input wire logic [6:0] pos_gate_out,
   input wire logic mux_to_pin_out,
   input wire logic hold_from_pin_out,
   input wire logic hold_from_mux_out,
   input wire logic converter_power_out,
   input wire logic sample_out,
   input wire logic converter_busy_out
);
   // One domain for every check
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Reset leaves the converter off and ungated
   AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n_in |=> !converter_busy_out && !converter_power_out && pos_gate_out == 7'h00)
      else $error("converter not idle after reset");
   // Idle with no path means every gate off
   AST_IDLE_GATED: assert property (!converter_busy_out && !hold_from_pin_out && !hold_from_mux_out |-> pos_gate_out == 7'h00)
      else $error("gate on while idle");
   // Routed mux never carries the temperature sensor
   AST_ROUTE_NO_TEMP: assert property (mux_to_pin_out |-> !pos_gate_out[0])
      else $error("temperature gate on while routed");
   // Routed: the two top pins are never inputs
   AST_ROUTE_TOP_PINS: assert property (mux_to_pin_out |-> pos_gate_out[6:5] == 2'b00)
      else $error("top pin gated while routed");
   // Routed: hold input comes from the pin only
   AST_ROUTE_HOLD: assert property (mux_to_pin_out |-> hold_from_pin_out && !hold_from_mux_out)
      else $error("hold path wrong while routed");
   // Start powers the core and opens the settle phase
   AST_START: assert property ($rose(converter_busy_out) |-> converter_power_out && sample_out)
      else $error("start did not power converter");
   // Settle phase holds for at least three clock cycles before the first trial
   AST_SETTLE: assert property ($rose(converter_power_out) |-> (sample_out || !converter_busy_out) [*3])
      else $error("settle phase too short");
   // Busy falling powers down at once
   AST_DONE: assert property ($fell(converter_busy_out) |-> !converter_power_out)
      else $error("power left on after busy cleared");
   // Busy clear keeps the clocked core stopped
   AST_POWER_BUSY: assert property (!converter_busy_out |-> !converter_power_out && !sample_out)
      else $error("converter active while busy clear");

   // Main scenarios
   COV_DONE: cover property ($fell(converter_busy_out));
   COV_ROUTED_RUN: cover property (mux_to_pin_out && converter_busy_out);
   COV_REFUSED: cover property (psel_in && penable_in && pslverr_out);
endmodule : acc_cc_asserts

bind acc_converter_control acc_cc_asserts u_chk (.sys_clk_in, .rst_n_in, .psel_in, .penable_in, .pslverr_out,
   .pos_gate_out, .mux_to_pin_out, .hold_from_pin_out, .hold_from_mux_out, .converter_power_out, .sample_out,
   .converter_busy_out);

/* File: verif/acc_analog_model.sv */
module acc_analog_model
(
   // Clock
   input wire logic sys_clk_in,
   // Conditioned input level and trial code
   input wire logic [9:0] level_in,
   input wire logic [9:0] trial_code_in,
   input wire logic path_on_in,
   // Comparator answer
   output logic compare_high_out
);
   logic junk_reg; // Changes every cycle when no path

   // Open path: no stable level reaches the comparator
   always @(posedge sys_clk_in)
   begin
      junk_reg <= (junk_reg === 1'b1) ? 1'b0 : 1'b1;
   end

   // Conditioned level compared with the trial code
   assign compare_high_out = path_on_in ? (level_in >= trial_code_in) : junk_reg;
endmodule : acc_analog_model

/* File: verif/tb_acc_converter_control.sv */
module tb_acc_converter_control
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Bus and switch signals
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, errv;
   logic cmp, mtp, mmtp, hfp, hfm, pwr, smp, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] pos_g, neg_g;
   logic [9:0] trial, level;
   int fail_count, checks, cyc, exp_res, prev, r;
   // Routed settings and expected gates
   logic [7:0] ctl_t [10] = '{8'hA4, 8'hD4, 8'h74, 8'h84, 8'h94, 8'hE4, 8'hF4, 8'hAC, 8'hBC, 8'hCC};
   logic [6:0] pos_t [10] = '{7'h02, 7'h10, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h02, 7'h04, 7'h00};
   logic [6:0] neg_t [10] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h04, 7'h02, 7'h00};
   logic [7:0] conv_t [3] = '{8'hA1, 8'hA3, 8'hA5};
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; $display("FAIL %s exp %0h got %0h", n, e, s); end end

   // Free running clock
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   acc_converter_control u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .compare_high_in(cmp), .pos_gate_out(pos_g), .neg_gate_out(neg_g),
      .mux_to_pin_out(mtp), .mux_minus_to_pin_out(mmtp), .hold_from_pin_out(hfp), .hold_from_mux_out(hfm),
      .converter_power_out(pwr), .sample_out(smp), .trial_code_out(trial), .converter_busy_out(busy));

   // Far side conditioning circuit
   acc_analog_model u_ana (.sys_clk_in(sys_clk), .level_in(level), .trial_code_in(trial),
      .path_on_in(hfp | hfm), .compare_high_out(cmp));

   // Verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         fail_count++;
      rd = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Bounded wait for busy to clear
   task automatic wait_idle;
      cyc = 0;
      do
      begin
         @(posedge sys_clk);
         cyc++;
      end
      while (busy !== 1'b0 && cyc < 2000);
   endtask : wait_idle

   // Read both result registers against the model
   task automatic chk_res;
      apb(1'b0, ACC_OFF_RES_HIGH, 32'h0);
      `CHK("result high", exp_res[9:2], rd[7:0])
      apb(1'b0, ACC_OFF_RES_LOW, 32'h0);
      `CHK("result low", {exp_res[1:0], 6'h00}, rd[7:0])
   endtask : chk_res

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, level} = '0;
      void'($urandom(83804));
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, ACC_OFF_CONTROL, 32'h0);
      `CHK("control reset", 8'h00, rd[7:0])
      apb(1'b0, 12'h010, 32'hFFFFFFFF);
      `CHK("unmapped error", 1'b1, errv)
      `CHK("unmapped data", 32'h0, rd)
      $display("test reset done");
      // Software access to results
      apb(1'b1, ACC_OFF_RES_HIGH, 32'h5A);
      apb(1'b0, ACC_OFF_RES_HIGH, 32'h0);
      `CHK("high rw", 8'h5A, rd[7:0])
      apb(1'b1, ACC_OFF_RES_LOW, 32'hFF);
      apb(1'b0, ACC_OFF_RES_LOW, 32'h0);
      `CHK("low rw", 8'hC0, rd[7:0])
      $display("test results rw done");
      // Routed channel map while idle
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b1, ACC_OFF_CONTROL, {24'h0, ctl_t[i]});
         @(negedge sys_clk);
         `CHK("pos gates", pos_t[i], pos_g)
         `CHK("neg gates", neg_t[i], neg_g)
         `CHK("mux pin", 1'b1, mtp)
         `CHK("hold pin", 1'b1, hfp)
         `CHK("mux minus", ctl_t[i][3], mmtp)
      end
      $display("test routing done");
      // Idle gating with and without amplifier
      apb(1'b1, ACC_OFF_CONTROL, 32'hA0);
      @(negedge sys_clk);
      `CHK("idle gates", 7'h00, pos_g)
      apb(1'b1, ACC_OFF_AMP_CFG, 32'h1);
      @(negedge sys_clk);
      `CHK("amp gates", 7'h02, pos_g)
      `CHK("amp hold", 1'b1, hfm)
      apb(1'b1, ACC_OFF_AMP_CFG, 32'h0);
      $display("test idle gating done");
      // Conversions: plain, divided, routed
      for (int i = 0; i < 3; i++)
      begin
         r = $urandom_range(1023);
         level <= r[9:0];
         exp_res = r;
         if (conv_t[i][2])
         begin
            apb(1'b1, ACC_OFF_CONTROL, {24'h0, conv_t[i] & 8'hFE});
            repeat (40) @(posedge sys_clk);
         end
         apb(1'b1, ACC_OFF_CONTROL, {24'h0, conv_t[i]});
         wait_idle();
         `CHK("slow clock", conv_t[i][1], cyc > 100)
         `CHK("busy done", 1'b0, busy)
         chk_res();
      end
      $display("test conversions done");
      // Abort keeps old results
      prev = exp_res;
      r = $urandom_range(1023);
      if (r == prev)
         r = r ^ 1;
      level <= r[9:0];
      apb(1'b1, ACC_OFF_CONTROL, 32'hA1);
      repeat (5) @(posedge sys_clk);
      apb(1'b1, ACC_OFF_CONTROL, 32'hA0);
      @(negedge sys_clk);
      `CHK("abort busy", 1'b0, busy)
      `CHK("abort power", 1'b0, pwr)
      apb(1'b0, ACC_OFF_RES_HIGH, 32'h0);
      `CHK("abort result", prev[9:2], rd[7:0])
      // Restart by zero then one
      apb(1'b1, ACC_OFF_CONTROL, 32'hA1);
      repeat (5) @(posedge sys_clk);
      apb(1'b1, ACC_OFF_CONTROL, 32'hA0);
      apb(1'b1, ACC_OFF_CONTROL, 32'hA1);
      exp_res = r;
      wait_idle();
      chk_res();
      $display("test abort done");
      complete_run();
   end
endmodule : tb_acc_converter_control
